/* File: cps_map.svh */
`ifndef CPS_MAP_SVH
`define CPS_MAP_SVH

// ****************************************
// register pointers
// ****************************************
`define CPS_PTR_DEVICE_STATUS       8'h00
`define CPS_PTR_CHAN1_RESULT_HIGH   8'h01
`define CPS_PTR_CHAN1_RESULT_LOW    8'h02
`define CPS_PTR_CHAN2_RESULT_HIGH   8'h03
`define CPS_PTR_CHAN2_RESULT_LOW    8'h04
`define CPS_PTR_CHAN1_MEAN_HIGH     8'h05
`define CPS_PTR_CHAN1_MEAN_LOW      8'h06
`define CPS_PTR_CHAN2_MEAN_HIGH     8'h07
`define CPS_PTR_CHAN2_MEAN_LOW      8'h08
`define CPS_PTR_CHAN1_BAND_HIGH     8'h09
`define CPS_PTR_CHAN1_HOLD_LOW      8'h0A
`define CPS_PTR_CHAN1_SETUP         8'h0B
`define CPS_PTR_CHAN2_BAND_HIGH     8'h0C
`define CPS_PTR_CHAN2_HOLD_LOW      8'h0D
`define CPS_PTR_CHAN2_SETUP         8'h0E
`define CPS_PTR_GLOBAL_CONFIG       8'h0F
`define CPS_PTR_SLEEP_TIMER         8'h10

// ****************************************
// reset values
// ****************************************
`define CPS_RST_BAND_HIGH           8'h08
`define CPS_RST_HOLD_LOW            8'h86
`define CPS_RST_SETUP               8'h0B
`define CPS_RST_GLOBAL_CONFIG       8'h19
`define CPS_RST_SLEEP_TIMER         6'h00

// ****************************************
// field positions
// ****************************************
`define CPS_ST_SLEEP_BIT            7
`define CPS_ST_CH2_OFFS_BIT         6
`define CPS_ST_CH2_DET_BIT          5
`define CPS_ST_CH1_OFFS_BIT         4
`define CPS_ST_CH1_DET_BIT          3
`define CPS_ST_LAST_CH_BIT          2
`define CPS_ST_CH2_DONE_BIT         1
`define CPS_ST_CH1_DONE_BIT         0
`define CPS_SU_RANGE_HI_BIT         7
`define CPS_SU_RANGE_LO_BIT         6
`define CPS_SU_HYST_BIT             4
`define CPS_SU_AVG_MSB              3
`define CPS_SU_MASK                 8'hDF
`define CPS_CFG_FIXED_BIT           7
`define CPS_CFG_CMP_B1_BIT          6
`define CPS_CFG_CMP_B0_BIT          5
`define CPS_CFG_EN1_BIT             4
`define CPS_CFG_EN2_BIT             3
`define CPS_CFG_OP_MSB              2
`define CPS_RES_PAD                 4'h0
`define CPS_AVG_TC_ONE              17'h00001

`endif

/* File: cps_pkg.sv */
package cps_pkg;

    typedef enum {CPS_LNK_IDLE, CPS_LNK_WAIT} cps_link_state_t;

    typedef struct packed {
        cps_link_state_t state;
        logic            req_tgl;
        logic            write;
        logic [7:0]      ptr;
        logic [7:0]      wdata;
        logic [7:0]      rdata;
        logic            done;
    } cps_link_t;

    typedef struct packed {
        logic                  req_seen;
        logic                  ack_tgl;
        logic [7:0]            rdata;
        logic [7:0]            shadow_lo;
        logic [1:0]            done_n;
        logic                  last_ch;
        logic [1:0]            detect;
        logic [1:0]            offs_n;
        logic [1:0][11:0]      result;
        logic [1:0][15:0]      mean;
        logic [1:0][7:0]       band_hi;
        logic [1:0][7:0]       hold_lo;
        logic [1:0][7:0]       setup;
        logic [7:0]            cfg;
        logic [5:0]            sleep_tmr;
        logic                  sleep_flag;
    } cps_core_t;

    typedef struct packed {
        logic s1;
        logic s2;
    } cps_sync_t;

endpackage

/* File: cps_sync.sv */
`timescale 1ns/1ps
module cps_sync (
    input  wire logic clk_in,    // destination clock
    input  wire logic clr_in,    // synchronous clear, active high
    input  wire logic d_in,      // level from another domain
    output logic      q_out      // synchronised level
);
    cps_pkg::cps_sync_t s_reg;
    cps_pkg::cps_sync_t s_next;

    // first stage is read only by the second
    always_comb
    begin
        s_next.s1 = clr_in ? 1'b0 : d_in;
        s_next.s2 = clr_in ? 1'b0 : s_reg.s1;
    end

    always_ff @(posedge clk_in)
    begin
        s_reg <= s_next;
    end

    assign q_out = s_reg.s2;
endmodule

/* File: cps_regbank.sv */
`timescale 1ns/1ps
`include "cps_map.svh"
// Overview of operation
// - Channel 1 byte at 0x09 is the sensitivity in adaptive mode and the upper fixed limit byte in fixed mode, reset 0x08.
// - Channel 2 byte at 0x0C is likewise sensitivity or upper fixed limit byte, readable and writable.
// - Channel 1 byte at 0x0A is the approach/recede timeout in adaptive mode and the lower fixed limit byte in fixed mode, reset 0x86.
// - Each setup byte holds two range bits on top, hysteresis enable at bit 4 and a 4-bit averaging field below.
// - A channel's done flag falls to 0 when its conversion finishes and returns to 1 when either of its result bytes is read or on reset.
// - Each 16-bit result register carries the 12-bit result on top and reads zero in its low four bits.
// - The averaging field selects a power-of-two time constant from 2 to 65,536 conversions.
// - Hysteresis is a quarter of the sensitivity when enabled in adaptive mode and none in fixed mode.
module cps_regbank (
    input  wire logic             clk_in,              // internal clock, 100 MHz
    input  wire logic             reset_in,            // synchronous reset, active high
    input  wire logic             link_clk_in,         // serial engine clock
    input  wire logic             link_req_in,         // one-cycle byte access request
    input  wire logic             link_write_in,       // 1 write, 0 read
    input  wire logic [7:0]       link_ptr_in,         // register pointer
    input  wire logic [7:0]       link_wdata_in,       // write byte
    output logic                  link_busy_out,       // access in flight
    output logic                  link_done_out,       // one-cycle access done
    output logic [7:0]            link_rdata_out,      // read byte
    input  wire logic [1:0]       conv_done_in,        // conversion finished, per channel
    input  wire logic [11:0]      conv_result_in,      // result of finished conversion
    input  wire logic [1:0][15:0] conv_mean_in,        // running averages
    input  wire logic [1:0]       conv_detect_in,      // comparator outputs
    input  wire logic [1:0]       conv_offs_step_in,   // offset moved in that conversion
    input  wire logic             sleep_or_low_in,     // power-down or low supply
    output logic                  fixed_limit_select_out, // fixed threshold mode
    output logic [1:0]            comparator_mode_out, // comparator mode bits
    output logic [1:0]            chan_enable_out,     // channel enables
    output logic [2:0]            op_mode_out,         // operating mode
    output logic [5:0]            sleep_timeout_out,   // power-down timeout
    output logic [1:0][7:0]       sensitivity_out,     // adaptive sensitivity
    output logic [1:0][7:0]       timeout_out,         // adaptive timeout
    output logic [1:0][15:0]      fixed_limit_out,     // fixed threshold
    output logic [1:0][7:0]       hysteresis_out,      // hysteresis amount
    output logic [1:0][1:0]       input_range_sel_out, // range select
    output logic [1:0][16:0]      avg_time_const_out   // averaging time constant
);
    // ****************************************
    // link domain
    // ****************************************
    cps_pkg::cps_link_t lnk_reg;
    cps_pkg::cps_link_t lnk_next;
    cps_pkg::cps_core_t core_reg;
    cps_pkg::cps_core_t core_next;
    logic               link_rst;
    logic               ack_sync;
    logic               req_sync;

    cps_sync u_rst_sync (
        .clk_in (link_clk_in),
        .clr_in (1'b0),
        .d_in   (reset_in),
        .q_out  (link_rst)
    );

    cps_sync u_ack_sync (
        .clk_in (link_clk_in),
        .clr_in (link_rst),
        .d_in   (core_reg.ack_tgl),
        .q_out  (ack_sync)
    );

    // requests while busy are dropped; the serial engine must wait for done
    always_comb
    begin
        lnk_next      = lnk_reg;
        lnk_next.done = 1'b0;
        unique case (lnk_reg.state)
            cps_pkg::CPS_LNK_IDLE:
            begin
                if (link_req_in)
                begin
                    lnk_next.state   = cps_pkg::CPS_LNK_WAIT;
                    lnk_next.req_tgl = ~lnk_reg.req_tgl;
                    lnk_next.write   = link_write_in;
                    lnk_next.ptr     = link_ptr_in;
                    lnk_next.wdata   = link_wdata_in;
                end
            end
            cps_pkg::CPS_LNK_WAIT:
            begin
                // core answer word is stable once the ack toggle arrives
                if (ack_sync == lnk_reg.req_tgl)
                begin
                    lnk_next.state = cps_pkg::CPS_LNK_IDLE;
                    lnk_next.rdata = core_reg.rdata;
                    lnk_next.done  = 1'b1;
                end
            end
        endcase
        if (link_rst)
        begin
            lnk_next.state   = cps_pkg::CPS_LNK_IDLE;
            lnk_next.req_tgl = 1'b0;
            lnk_next.write   = 1'b0;
            lnk_next.ptr     = 8'h00;
            lnk_next.wdata   = 8'h00;
            lnk_next.rdata   = 8'h00;
            lnk_next.done    = 1'b0;
        end
    end

    always_ff @(posedge link_clk_in)
    begin
        lnk_reg <= lnk_next;
    end

    assign link_busy_out  = (lnk_reg.state == cps_pkg::CPS_LNK_WAIT);
    assign link_done_out  = lnk_reg.done;
    assign link_rdata_out = lnk_reg.rdata;

    // ****************************************
    // core domain
    // ****************************************
    cps_sync u_req_sync (
        .clk_in (clk_in),
        .clr_in (reset_in),
        .d_in   (lnk_reg.req_tgl),
        .q_out  (req_sync)
    );

    logic       acc_go;
    logic [7:0] status_byte;
    logic [7:0] rd_mux;
    logic [1:0] rd_clear;

    assign acc_go = (req_sync != core_reg.req_seen);

    always_comb
    begin
        status_byte                        = 8'h00;
        status_byte[`CPS_ST_SLEEP_BIT]     = core_reg.sleep_flag;
        status_byte[`CPS_ST_CH2_OFFS_BIT]  = core_reg.offs_n[1];
        status_byte[`CPS_ST_CH2_DET_BIT]   = core_reg.detect[1];
        status_byte[`CPS_ST_CH1_OFFS_BIT]  = core_reg.offs_n[0];
        status_byte[`CPS_ST_CH1_DET_BIT]   = core_reg.detect[0];
        status_byte[`CPS_ST_LAST_CH_BIT]   = core_reg.last_ch;
        status_byte[`CPS_ST_CH2_DONE_BIT]  = core_reg.done_n[1];
        status_byte[`CPS_ST_CH1_DONE_BIT]  = core_reg.done_n[0];
    end

    // low bytes come from the shadow caught on the high-byte read
    always_comb
    begin
        rd_mux   = 8'h00;
        rd_clear = 2'b00;
        unique case (lnk_reg.ptr)
            `CPS_PTR_DEVICE_STATUS:     rd_mux = status_byte;
            `CPS_PTR_CHAN1_RESULT_HIGH: rd_mux = core_reg.result[0][11:4];
            `CPS_PTR_CHAN2_RESULT_HIGH: rd_mux = core_reg.result[1][11:4];
            `CPS_PTR_CHAN1_RESULT_LOW,
            `CPS_PTR_CHAN2_RESULT_LOW,
            `CPS_PTR_CHAN1_MEAN_LOW,
            `CPS_PTR_CHAN2_MEAN_LOW:    rd_mux = core_reg.shadow_lo;
            `CPS_PTR_CHAN1_MEAN_HIGH:   rd_mux = core_reg.mean[0][15:8];
            `CPS_PTR_CHAN2_MEAN_HIGH:   rd_mux = core_reg.mean[1][15:8];
            `CPS_PTR_CHAN1_BAND_HIGH:   rd_mux = core_reg.band_hi[0];
            `CPS_PTR_CHAN1_HOLD_LOW:    rd_mux = core_reg.hold_lo[0];
            `CPS_PTR_CHAN1_SETUP:       rd_mux = core_reg.setup[0];
            `CPS_PTR_CHAN2_BAND_HIGH:   rd_mux = core_reg.band_hi[1];
            `CPS_PTR_CHAN2_HOLD_LOW:    rd_mux = core_reg.hold_lo[1];
            `CPS_PTR_CHAN2_SETUP:       rd_mux = core_reg.setup[1];
            `CPS_PTR_GLOBAL_CONFIG:     rd_mux = core_reg.cfg;
            `CPS_PTR_SLEEP_TIMER:       rd_mux = {2'b00, core_reg.sleep_tmr};
            default:                    rd_mux = 8'h00;
        endcase
        if (lnk_reg.ptr == `CPS_PTR_CHAN1_RESULT_HIGH || lnk_reg.ptr == `CPS_PTR_CHAN1_RESULT_LOW)
        begin
            rd_clear[0] = 1'b1;
        end
        if (lnk_reg.ptr == `CPS_PTR_CHAN2_RESULT_HIGH || lnk_reg.ptr == `CPS_PTR_CHAN2_RESULT_LOW)
        begin
            rd_clear[1] = 1'b1;
        end
    end

    always_comb
    begin
        core_next            = core_reg;
        core_next.sleep_flag = sleep_or_low_in;
        if (acc_go)
        begin
            core_next.req_seen = req_sync;
            if (lnk_reg.write)
            begin
                unique case (lnk_reg.ptr)
                    `CPS_PTR_CHAN1_BAND_HIGH: core_next.band_hi[0] = lnk_reg.wdata;
                    `CPS_PTR_CHAN1_HOLD_LOW:  core_next.hold_lo[0] = lnk_reg.wdata;
                    `CPS_PTR_CHAN1_SETUP:     core_next.setup[0] = lnk_reg.wdata & `CPS_SU_MASK;
                    `CPS_PTR_CHAN2_BAND_HIGH: core_next.band_hi[1] = lnk_reg.wdata;
                    `CPS_PTR_CHAN2_HOLD_LOW:  core_next.hold_lo[1] = lnk_reg.wdata;
                    `CPS_PTR_CHAN2_SETUP:     core_next.setup[1] = lnk_reg.wdata & `CPS_SU_MASK;
                    `CPS_PTR_GLOBAL_CONFIG:   core_next.cfg = lnk_reg.wdata;
                    `CPS_PTR_SLEEP_TIMER:     core_next.sleep_tmr = lnk_reg.wdata[5:0];
                    default:                  core_next.rdata = core_reg.rdata;
                endcase
                core_next.rdata = 8'h00;
            end
            else
            begin
                core_next.rdata = rd_mux;
                // catch low byte with high byte
                unique case (lnk_reg.ptr)
                    `CPS_PTR_CHAN1_RESULT_HIGH:
                        core_next.shadow_lo = {core_reg.result[0][3:0], `CPS_RES_PAD};
                    `CPS_PTR_CHAN2_RESULT_HIGH:
                        core_next.shadow_lo = {core_reg.result[1][3:0], `CPS_RES_PAD};
                    `CPS_PTR_CHAN1_MEAN_HIGH:
                        core_next.shadow_lo = core_reg.mean[0][7:0];
                    `CPS_PTR_CHAN2_MEAN_HIGH:
                        core_next.shadow_lo = core_reg.mean[1][7:0];
                    default:
                        core_next.shadow_lo = core_reg.shadow_lo;
                endcase
                core_next.done_n = core_reg.done_n | rd_clear;
            end
            core_next.ack_tgl = req_sync;
        end
        for (int ch = 0; ch < 2; ch++)
        begin
            if (conv_done_in[ch])
            begin
                core_next.done_n[ch] = 1'b0;
                core_next.result[ch] = conv_result_in;
                core_next.mean[ch]   = conv_mean_in[ch];
                core_next.detect[ch] = conv_detect_in[ch];
                core_next.offs_n[ch] = ~conv_offs_step_in[ch];
                core_next.last_ch    = (ch == 1);
            end
        end
        if (reset_in)
        begin
            core_next.req_seen   = 1'b0;
            core_next.ack_tgl    = 1'b0;
            core_next.rdata      = 8'h00;
            core_next.shadow_lo  = 8'h00;
            core_next.done_n     = 2'b11;
            core_next.last_ch    = 1'b0;
            core_next.detect     = 2'b00;
            core_next.offs_n     = 2'b11;
            core_next.result     = '0;
            core_next.mean       = '0;
            core_next.band_hi[0] = `CPS_RST_BAND_HIGH;
            core_next.band_hi[1] = `CPS_RST_BAND_HIGH;
            core_next.hold_lo[0] = `CPS_RST_HOLD_LOW;
            core_next.hold_lo[1] = `CPS_RST_HOLD_LOW;
            core_next.setup[0]   = `CPS_RST_SETUP;
            core_next.setup[1]   = `CPS_RST_SETUP;
            core_next.cfg        = `CPS_RST_GLOBAL_CONFIG;
            core_next.sleep_tmr  = `CPS_RST_SLEEP_TIMER;
            core_next.sleep_flag = 1'b0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        core_reg <= core_next;
    end

    // ****************************************
    // decoded controls
    // ****************************************
    assign fixed_limit_select_out = core_reg.cfg[`CPS_CFG_FIXED_BIT];
    assign comparator_mode_out    = {core_reg.cfg[`CPS_CFG_CMP_B1_BIT],
                                     core_reg.cfg[`CPS_CFG_CMP_B0_BIT]};
    assign chan_enable_out        = {core_reg.cfg[`CPS_CFG_EN2_BIT],
                                     core_reg.cfg[`CPS_CFG_EN1_BIT]};
    assign op_mode_out            = core_reg.cfg[`CPS_CFG_OP_MSB:0];
    assign sleep_timeout_out      = core_reg.sleep_tmr;

    always_comb
    begin
        for (int ch = 0; ch < 2; ch++)
        begin
            if (fixed_limit_select_out)
            begin
                sensitivity_out[ch] = 8'h00;
                timeout_out[ch]     = 8'h00;
                fixed_limit_out[ch] = {core_reg.band_hi[ch], core_reg.hold_lo[ch]};
            end
            else
            begin
                sensitivity_out[ch] = core_reg.band_hi[ch];
                timeout_out[ch]     = core_reg.hold_lo[ch];
                fixed_limit_out[ch] = 16'h0000;
            end
            if (!fixed_limit_select_out && core_reg.setup[ch][`CPS_SU_HYST_BIT])
            begin
                hysteresis_out[ch] = {2'b00, core_reg.band_hi[ch][7:2]};
            end
            else
            begin
                hysteresis_out[ch] = 8'h00;
            end
            input_range_sel_out[ch] = {core_reg.setup[ch][`CPS_SU_RANGE_HI_BIT],
                                       core_reg.setup[ch][`CPS_SU_RANGE_LO_BIT]};
            // two to the power field plus one
            avg_time_const_out[ch] = `CPS_AVG_TC_ONE
                << ({1'b0, core_reg.setup[ch][`CPS_SU_AVG_MSB:0]} + 5'h01);
        end
    end
endmodule

/* File: cps_regbank_asserts.sv */
`timescale 1ns/1ps
module cps_regbank_chk (
    input  wire logic             clk_in,                 // core clock
    input  wire logic             reset_in,               // sync reset
    input  wire logic             link_clk_in,            // link clock
    input  wire logic             link_req_in,            // request
    input  wire logic             link_busy_out,          // in flight
    input  wire logic             link_done_out,          // done pulse
    input  wire logic [7:0]       link_rdata_out,         // read byte
    input  wire logic             fixed_limit_select_out, // fixed mode
    input  wire logic [1:0][7:0]  sensitivity_out,        // sensitivity
    input  wire logic [1:0][7:0]  timeout_out,            // timeout
    input  wire logic [1:0][15:0] fixed_limit_out,        // fixed limit
    input  wire logic [1:0][7:0]  hysteresis_out,         // hysteresis
    input  wire logic [1:0][16:0] avg_time_const_out      // averaging
);
// link side leaves reset some link cycles after the core does
logic [2:0] lrst_sh;
always_ff @(posedge link_clk_in)
begin
    lrst_sh <= {lrst_sh[1:0], reset_in};
end
// ****************************************
// link handshake
// ****************************************
chk_take_busy: assert property (@(posedge link_clk_in) disable iff (|lrst_sh)
    link_req_in && !link_busy_out |=> link_busy_out) else $error("request not taken");
chk_done_pulse: assert property (@(posedge link_clk_in) disable iff (|lrst_sh)
    link_done_out |-> !link_busy_out ##1 !link_done_out) else $error("done not a pulse");
chk_busy_bound: assert property (@(posedge link_clk_in) disable iff (|lrst_sh)
    $rose(link_busy_out) |-> link_busy_out[*2] ##[1:20] link_done_out)
    else $error("access never finished");
chk_rdata_hold: assert property (@(posedge link_clk_in) disable iff (|lrst_sh)
    !link_done_out |-> $stable(link_rdata_out)) else $error("read byte moved");
// ****************************************
// threshold and averaging decodes
// ****************************************
chk_fixed_quiet: assert property (@(posedge clk_in) disable iff (reset_in)
    fixed_limit_select_out |-> sensitivity_out == '0 && timeout_out == '0
    && hysteresis_out == '0) else $error("adaptive values leak in fixed mode");
chk_adapt_zero: assert property (@(posedge clk_in) disable iff (reset_in)
    !fixed_limit_select_out |-> fixed_limit_out == '0) else $error("fixed limit in adaptive");
chk_hyst_quarter: assert property (@(posedge clk_in) disable iff (reset_in)
    !fixed_limit_select_out |-> hysteresis_out[0] == 8'h00
    || hysteresis_out[0] == (sensitivity_out[0] >> 2)) else $error("hysteresis not a quarter");
chk_fixed_join: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(fixed_limit_select_out) |-> fixed_limit_out[0]
    == {$past(sensitivity_out[0]), $past(timeout_out[0])}) else $error("limit bytes misjoined");
chk_avg_pow2: assert property (@(posedge clk_in) disable iff (reset_in)
    $onehot(avg_time_const_out[1]) && !avg_time_const_out[1][0])
    else $error("time constant out of range");
cover property (@(posedge link_clk_in) link_done_out);
cover property (@(posedge clk_in) $rose(fixed_limit_select_out));
cover property (@(posedge clk_in) hysteresis_out[0] != 8'h00);
endmodule
bind cps_regbank cps_regbank_chk u_chk (
    .clk_in(clk_in), .reset_in(reset_in), .link_clk_in(link_clk_in),
    .link_req_in(link_req_in), .link_busy_out(link_busy_out),
    .link_done_out(link_done_out), .link_rdata_out(link_rdata_out),
    .fixed_limit_select_out(fixed_limit_select_out), .sensitivity_out(sensitivity_out),
    .timeout_out(timeout_out), .fixed_limit_out(fixed_limit_out),
    .hysteresis_out(hysteresis_out), .avg_time_const_out(avg_time_const_out));

/* File: cps_host_model.sv */
`timescale 1ns/1ps
module cps_host_model (
    input  wire logic       link_clk_in, // link clock
    input  wire logic       done_in,     // done pulse
    input  wire logic [7:0] rdata_in,    // read byte
    output logic            req_out,     // request
    output logic            write_out,   // write select
    output logic [7:0]      ptr_out,     // pointer
    output logic [7:0]      wdata_out    // write byte
);
    initial
    begin
        req_out = 1'b0;
        write_out = 1'b0;
        ptr_out = 8'h00;
        wdata_out = 8'h00;
    end
    // one byte access; lines go inverse once taken so stale values never pass
    task automatic access(input logic w, input logic [7:0] p, input logic [7:0] d,
                          output logic [7:0] q);
        int n;
        q = 8'hXX;
        @(posedge link_clk_in);
        #1;
        {req_out, write_out, ptr_out, wdata_out} = {1'b1, w, p, d};
        @(posedge link_clk_in);
        #1;
        {req_out, write_out, ptr_out, wdata_out} = {1'b0, ~w, ~p, ~d};
        for (n = 0; n < 40; n++)
        begin
            @(posedge link_clk_in);
            #1;
            if (done_in === 1'b1)
            begin
                q = rdata_in;
                break;
            end
        end
    endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
`include "cps_map.svh"
module tb_top;
    logic             clk_in, reset_in, link_clk, busy, done, fixed_sel, sleep_low;
    logic             req, wr;
    logic [7:0]       ptr, wdata, rdata;
    logic [1:0]       conv_done, det, offs, cmp_mode, chan_en;
    logic [11:0]      result;
    logic [2:0]       op_mode;
    logic [5:0]       sleep_to;
    logic [1:0][7:0]  sens, tmo, hyst;
    logic [1:0][15:0] mean, flim;
    logic [1:0][1:0]  rng;
    logic [1:0][16:0] avg;
    logic [7:0]       q;
    int               mismatches, checked, cycles;

    cps_regbank dut (.clk_in(clk_in), .reset_in(reset_in), .link_clk_in(link_clk),
        .link_req_in(req), .link_write_in(wr), .link_ptr_in(ptr), .link_wdata_in(wdata),
        .link_busy_out(busy), .link_done_out(done), .link_rdata_out(rdata),
        .conv_done_in(conv_done), .conv_result_in(result), .conv_mean_in(mean),
        .conv_detect_in(det), .conv_offs_step_in(offs), .sleep_or_low_in(sleep_low),
        .fixed_limit_select_out(fixed_sel), .comparator_mode_out(cmp_mode),
        .chan_enable_out(chan_en), .op_mode_out(op_mode), .sleep_timeout_out(sleep_to),
        .sensitivity_out(sens), .timeout_out(tmo), .fixed_limit_out(flim),
        .hysteresis_out(hyst), .input_range_sel_out(rng), .avg_time_const_out(avg));
    cps_host_model host (.link_clk_in(link_clk), .done_in(done), .rdata_in(rdata),
        .req_out(req), .write_out(wr), .ptr_out(ptr), .wdata_out(wdata));

    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial
    begin
        link_clk = 1'b0;
        #7;
        forever #24 link_clk = ~link_clk;
    end
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic rd_chk(input logic [7:0] p, input logic [7:0] exp);
        host.access(1'b0, p, 8'h00, q);
        chk($sformatf("reg %0h", p), {24'h0, exp}, {24'h0, q});
    endtask
    task automatic conv(input int ch, input logic [11:0] r, input logic [15:0] m,
                        input logic d, input logic o);
        @(posedge clk_in);
        #1;
        {result, mean[ch], det[ch], offs[ch], conv_done[ch]} = {r, m, d, o, 1'b1};
        @(posedge clk_in);
        #1;
        conv_done = 2'b00;
        @(posedge clk_in);
    endtask
    task automatic wrap_up();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        logic [7:0] exp [0:17];
        exp = '{8'h53, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08,
                8'h86, 8'h0B, 8'h08, 8'h86, 8'h0B, 8'h19, 8'h00, 8'h00};
        for (int p = 0; p < 18; p++)
            rd_chk(p[7:0], exp[p]);
        chk("avg reset", 32'h1000, {15'h0, avg[0]});
        $display("test reset_values done");
    endtask
    task automatic t_write();
        logic [7:0] pt [0:9] = '{8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10,
                                  8'h00, 8'h01};
        logic [7:0] wv [0:9] = '{8'hA5, 8'h3C, 8'hFF, 8'h5A, 8'hC3, 8'h7A, 8'h7D, 8'hFF,
                                  8'hFF, 8'hFF};
        logic [7:0] ev [0:9] = '{8'hA5, 8'h3C, 8'hDF, 8'h5A, 8'hC3, 8'h5A, 8'h7D, 8'h3F,
                                  8'h53, 8'h00};
        for (int i = 0; i < 10; i++)
            host.access(1'b1, pt[i], wv[i], q);
        for (int i = 0; i < 10; i++)
            rd_chk(pt[i], ev[i]);
        chk("sens tmo", 32'h5AC33C, {8'h0, sens[1], tmo});
        chk("range", 32'h7, {28'h0, rng});
        chk("hyst", 32'h1629, {16'h0, hyst});
        chk("avg ch1", 32'h10000, {15'h0, avg[0]});
        chk("avg ch2", 32'h800, {15'h0, avg[1]});
        chk("cfg", 32'h3FEE, {18'h0, sleep_to, cmp_mode, op_mode, chan_en, fixed_sel});
        host.access(1'b1, `CPS_PTR_GLOBAL_CONFIG, 8'h9D, q);
        chk("limits", 32'h5AC3A53C, flim);
        chk("fixed hyst", 32'h0, {16'h0, hyst});
        $display("test write_readback done");
    endtask
    task automatic t_conv();
        sleep_low = 1'b1;
        conv(0, 12'hABC, 16'h1234, 1'b1, 1'b1);
        rd_chk(`CPS_PTR_DEVICE_STATUS, 8'hCA);
        rd_chk(`CPS_PTR_CHAN1_RESULT_HIGH, 8'hAB);
        rd_chk(`CPS_PTR_CHAN1_RESULT_LOW, 8'hC0);
        rd_chk(`CPS_PTR_CHAN1_MEAN_HIGH, 8'h12);
        rd_chk(`CPS_PTR_CHAN1_MEAN_LOW, 8'h34);
        rd_chk(`CPS_PTR_DEVICE_STATUS, 8'hCB);
        sleep_low = 1'b0;
        conv(1, 12'h123, 16'h4567, 1'b0, 1'b0);
        rd_chk(`CPS_PTR_DEVICE_STATUS, 8'h4D);
        rd_chk(`CPS_PTR_CHAN2_RESULT_HIGH, 8'h12);
        rd_chk(`CPS_PTR_CHAN2_RESULT_LOW, 8'h30);
        rd_chk(`CPS_PTR_CHAN2_MEAN_HIGH, 8'h45);
        rd_chk(`CPS_PTR_CHAN2_MEAN_LOW, 8'h67);
        rd_chk(`CPS_PTR_DEVICE_STATUS, 8'h4F);
        $display("test conversion done");
    endtask
    // hang guard: whole run needs about 1300 core cycles
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            mismatches++;
            wrap_up();
        end
    end
    initial
    begin
        {reset_in, conv_done, result, mean, det, offs, sleep_low} = '0;
        reset_in = 1'b1;
        repeat (12) @(posedge clk_in);
        #1;
        reset_in = 1'b0;
        repeat (5) @(posedge link_clk);
        t_reset();
        t_write();
        t_conv();
        wrap_up();
    end
endmodule
